//--- core/ctw_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CTW_MAP_SVH
`define CTW_MAP_SVH
`define CTW_ADDR_THERM 8'h12
`define CTW_ADDR_WDOG 8'h13
`define CTW_ADDR_RESTART 8'hfa
`define CTW_BIT_BYPASS 5
`define CTW_BIT_HEALTHY 4
`define CTW_BIT_AUXREG 2
`define CTW_BIT_WD_INHIBIT 1
`define CTW_THERM_RESET 8'h00
`define CTW_WDOG_RESET 8'h6c
`define CTW_WDOG_WMASK 8'hfe
`define CTW_RESTART_CODE 8'hb5
`define CTW_RESTART_READ 8'hff
`define CTW_UNMAPPED_READ 8'h00
`define CTW_REFRESH_NS 1000000000
`define CTW_CLK_NS 20
`define CTW_WD_S 32
`endif

//--- core/ctw_pkg.sv
// Types shared by the charger thermal and watchdog register bank
package ctw_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctw_req_type;

    typedef struct packed {
        logic healthy;
        logic [3:0] above;
    } ctw_therm_type;
endpackage : ctw_pkg

//--- core/ctw_regs.sv
// Thermistor status, watchdog control and charge-restart register bank
`timescale 1ns/1ps
`include "ctw_map.svh"

module ctw_regs #(
    parameter int unsigned REFRESH_CYCLES = `CTW_REFRESH_NS / `CTW_CLK_NS,
    parameter int unsigned WD_CYCLES = `CTW_WD_S * (`CTW_REFRESH_NS / `CTW_CLK_NS)
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port from the serial control block
    input wire ctw_pkg::ctw_req_type i_req,
    output logic [7:0] o_rdata,
    // Analog thermistor comparator pins
    input wire logic [3:0] i_above_raw,
    input wire logic i_sensor_fault_raw,
    // Charger state and watchdog service
    input wire logic i_charge_done,
    input wire logic i_wd_kick,
    // Controls to the charger core
    output ctw_pkg::ctw_therm_type o_therm_effective,
    output logic o_temp_policy_active,
    output logic o_aux_regulator_on,
    output logic o_restart_pulse,
    output logic o_wd_expired
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change taken when stages 2 and 3 agree
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] stable_reg;
    logic [4:0] stable_next;

    assign stable_next = (sync2_reg == sync3_reg) ? sync3_reg : stable_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
            stable_reg <= 5'h00;
        end else begin
            sync1_reg <= {i_sensor_fault_raw, i_above_raw};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stable_reg <= stable_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Once-a-second sample of threshold flags
    logic [29:0] sec_cnt_reg;
    logic [29:0] sec_cnt_next;
    wire sec_tick = (sec_cnt_reg == 30'(REFRESH_CYCLES - 1));
    ctw_pkg::ctw_therm_type flags_reg;
    ctw_pkg::ctw_therm_type flags_next;

    assign sec_cnt_next = sec_tick ? 30'h0 : sec_cnt_reg + 30'h1;
    assign flags_next.above = sec_tick ? stable_reg[3:0] : flags_reg.above;
    assign flags_next.healthy = ~stable_reg[4];

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sec_cnt_reg <= 30'h0;
            flags_reg <= '0;
        end else begin
            sec_cnt_reg <= sec_cnt_next;
            flags_reg <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    logic [7:0] therm_ctl_reg;
    logic [7:0] wdog_reg;
    logic [7:0] therm_ctl_next;
    logic [7:0] wdog_next;
    wire wr_therm = i_req.wr && (i_req.addr == `CTW_ADDR_THERM);
    wire wr_wdog = i_req.wr && (i_req.addr == `CTW_ADDR_WDOG);
    wire wr_restart = i_req.wr && (i_req.addr == `CTW_ADDR_RESTART);

    assign therm_ctl_next = wr_therm ? (i_req.wdata & 8'h20) : therm_ctl_reg;
    // bit 1 inhibits the watchdog, bit 2 drives the aux regulator, bit 0 kept zero
    assign wdog_next = wr_wdog ? (i_req.wdata & `CTW_WDOG_WMASK) : wdog_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            therm_ctl_reg <= `CTW_THERM_RESET;
            wdog_reg <= `CTW_WDOG_RESET;
        end else begin
            therm_ctl_reg <= therm_ctl_next;
            wdog_reg <= wdog_next;
        end
    end

    wire bypass = therm_ctl_reg[`CTW_BIT_BYPASS];
    wire wd_inhibit = wdog_reg[`CTW_BIT_WD_INHIBIT];

    ////////////////////////////////////////////////////////////////////////
    // Effect of temperature results on charging
    // results steer charging unless the bypass bit is set
    assign o_temp_policy_active = ~bypass;
    assign o_therm_effective = bypass ? ctw_pkg::ctw_therm_type'(5'h10) : flags_reg;
    assign o_aux_regulator_on = wdog_reg[`CTW_BIT_AUXREG];

    ////////////////////////////////////////////////////////////////////////
    // Charge restart command
    logic restart_reg;
    // code only in charge-done, other values ignored
    wire restart_next = wr_restart && (i_req.wdata == `CTW_RESTART_CODE) && i_charge_done;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= restart_next;
        end
    end
    assign o_restart_pulse = restart_reg;

    ////////////////////////////////////////////////////////////////////////
    // Long-interval watchdog
    logic [31:0] wd_cnt_reg;
    logic [31:0] wd_cnt_next;
    logic wd_exp_reg;
    logic wd_exp_next;
    wire wd_end = (wd_cnt_reg == 32'(WD_CYCLES - 1));

    assign wd_cnt_next = (wd_inhibit || i_wd_kick || i_req.wr || wd_end) ? 32'h0 : wd_cnt_reg + 32'h1;
    assign wd_exp_next = wd_inhibit ? 1'b0 : (wd_exp_reg || wd_end);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wd_cnt_reg <= 32'h0;
            wd_exp_reg <= 1'b0;
        end else begin
            wd_cnt_reg <= wd_cnt_next;
            wd_exp_reg <= wd_exp_next;
        end
    end
    assign o_wd_expired = wd_exp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    wire [7:0] therm_view = {2'b00, bypass, flags_reg.healthy, flags_reg.above};
    assign rdata_next = !i_req.rd ? rdata_reg :
        (i_req.addr == `CTW_ADDR_THERM) ? therm_view :
        (i_req.addr == `CTW_ADDR_WDOG) ? wdog_reg :
        (i_req.addr == `CTW_ADDR_RESTART) ? `CTW_RESTART_READ : `CTW_UNMAPPED_READ;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign o_rdata = rdata_reg;

endmodule : ctw_regs

//--- testbench/ctw_regs_props.sv
// Concurrent checks on the thermal and watchdog register bank
`timescale 1ns/1ps
module ctw_regs_props #(
    parameter int unsigned REFRESH_CYCLES = 16,
    parameter int unsigned WD_CYCLES = 64
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire ctw_pkg::ctw_req_type i_req,
    input wire logic [7:0] o_rdata,
    input wire logic i_sensor_fault_raw,
    input wire logic i_charge_done,
    input wire ctw_pkg::ctw_therm_type o_therm_effective,
    input wire logic o_temp_policy_active,
    input wire logic o_restart_pulse,
    input wire logic o_wd_expired
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire go = i_req.wr && i_req.addr == 8'hfa && i_req.wdata == 8'hb5 && i_charge_done;
    wire rd_t = i_req.rd && i_req.addr == 8'h12;
    a_restart_fires: assert property (go |=> o_restart_pulse)
        else $error("restart missed");
    a_restart_only_code: assert property (o_restart_pulse |-> $past(go))
        else $error("stray restart");
    a_restart_reads_ones: assert property (i_req.rd && i_req.addr == 8'hfa |=> o_rdata == 8'hff)
        else $error("restart readback");
    a_therm_top_zero: assert property (rd_t |=> o_rdata[7:6] == 2'b00)
        else $error("therm top bits");
    a_wdog_bit_zero: assert property (i_req.rd && i_req.addr == 8'h13 |=> !o_rdata[0])
        else $error("wdog bit0");
    a_bypass_masks: assert property (!o_temp_policy_active && $past(!o_temp_policy_active) |-> o_therm_effective == 5'h10)
        else $error("bypass leak");
    a_healthy_on_fault: assert property (i_sensor_fault_raw [*6] ##1 rd_t |=> !o_rdata[4])
        else $error("fault not shown");
    a_inhibit_clears: assert property (i_req.wr && i_req.addr == 8'h13 && i_req.wdata[1] |-> ##3 !o_wd_expired)
        else $error("inhibit ignored");
    c_restart: cover property (o_restart_pulse);
    c_expired: cover property ($rose(o_wd_expired));
    c_bypass: cover property (!o_temp_policy_active);
endmodule : ctw_regs_props
bind ctw_regs ctw_regs_props #(.REFRESH_CYCLES(REFRESH_CYCLES), .WD_CYCLES(WD_CYCLES)) ctw_regs_props_i (.*);

//--- testbench/ctw_host_model.sv
// Host driver of the register request port
`timescale 1ns/1ps
module ctw_host_model (
    input wire logic i_mclk,
    output ctw_pkg::ctw_req_type o_req,
    input wire logic [7:0] i_rdata
);
    initial o_req = '0;
    // Between transfers addr and wdata show the inverse of the last transfer, wr and rd low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge i_mclk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_mclk);
        q = i_rdata;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : ctw_host_model

//--- testbench/ctw_regs_tb.sv
// Self-checking bench for the thermal and watchdog register bank
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module ctw_regs_tb;
    localparam int unsigned REF = 16;
    localparam int unsigned WD = 64;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_above_raw = 4'h0;
    logic i_sensor_fault_raw = 1'b0;
    logic i_charge_done = 1'b0;
    logic i_wd_kick = 1'b0;
    logic [7:0] q;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    ctw_pkg::ctw_req_type i_req;
    logic [7:0] o_rdata;
    ctw_pkg::ctw_therm_type o_therm_effective;
    logic o_temp_policy_active, o_aux_regulator_on, o_restart_pulse, o_wd_expired;
    ctw_regs #(.REFRESH_CYCLES(REF), .WD_CYCLES(WD)) ctw_regs_i (.*);
    ctw_host_model ctw_host_model_i (.i_mclk(i_mclk), .o_req(i_req), .i_rdata(o_rdata));
    initial forever #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctw_host_model_i.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ctw_host_model_i.xfer(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : idle
    initial begin
        idle(3);
        i_rst = 1'b0;
        rd(8'h13, 8'h6c);
        rd(8'hfa, 8'hff);
        idle(8);
        rd(8'h12, 8'h10);
        rd(8'h40, 8'h00);
        wr(8'h13, 8'hff);
        rd(8'h13, 8'hfe);
        `CHK(o_aux_regulator_on, 1'b1)
        i_above_raw = 4'ha;
        wr(8'h12, 8'hff);
        `CHK(o_temp_policy_active, 1'b0)
        idle(2 * REF + 8);
        `CHK(o_therm_effective, 5'h10)
        rd(8'h12, 8'h3a);
        i_sensor_fault_raw = 1'b1;
        idle(8);
        rd(8'h12, 8'h2a);
        wr(8'h12, 8'h00);
        idle(2);
        `CHK(o_therm_effective, 5'h0a)
        wr(8'hfa, 8'hb5);
        `CHK(o_restart_pulse, 1'b0)
        i_charge_done = 1'b1;
        wr(8'hfa, 8'h5b);
        `CHK(o_restart_pulse, 1'b0)
        wr(8'hfa, 8'hb5);
        `CHK(o_restart_pulse, 1'b1)
        rd(8'hfa, 8'hff);
        wr(8'h13, 8'h6c);
        repeat (4) begin
            idle(WD / 2);
            i_wd_kick = 1'b1;
            idle(1);
            i_wd_kick = 1'b0;
        end
        `CHK(o_wd_expired, 1'b0)
        idle(WD + 8);
        `CHK(o_wd_expired, 1'b1)
        wr(8'h13, 8'h6e);
        idle(WD + 8);
        `CHK(o_wd_expired, 1'b0)
        stop_test();
    end
endmodule : ctw_regs_tb
